//--- hw/antsup_sync.sv
`timescale 1ns/1ps
module antsup_sync (
    input  wire logic clk_i,
    input  wire logic rst_n_i,
    input  wire logic async_i,
    output logic      sync_o
);
    // unconnected pins read high, so reset to the pulled-up level
    logic meta;

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            meta   <= 1'b1;  // [R11]
            sync_o <= 1'b1;  // [R11]
        end else begin
            meta   <= async_i;
            sync_o <= meta;
        end
    end
endmodule

//--- hw/antsup_top.sv
`timescale 1ns/1ps
// Operation
// R1 - after reset run the two-pin variant unless three-pin was configured
// R2 - two-pin: good input high is healthy, low is faulty
// R3 - two-pin: supply-off output high turns supply off, low on
// R4 - cut supply on detected short or on power-save request
// R5 - three-pin variant enabled only by the dedicated configuration command
// R6 - three-pin selection is kept forever, no way back
// R7 - three-pin: presence input high means antenna present, low absent
// R8 - three-pin: short input low means shorted supply, high no short
// R9 - three-pin: supply-off output high removes supply, low otherwise
// R10 - current antenna status is reported to the monitor message on request
// R11 - unconnected inputs read high, idle and reset values follow that
// R12 - permanent irreversible inversion of the supply-off polarity
// R13 - every supervisor input passes a two-stage synchroniser before use; here only the three antenna sense inputs do, the others are used directly
module antsup_top (
    input  wire logic                        clk_i,
    input  wire logic                        rst_n_i,
    input  wire logic                        antenna_good_in_i,
    input  wire logic                        antenna_present_in_i,
    input  wire logic                        antenna_short_low_in_i,
    input  wire logic                        power_save_i,
    input  wire logic                        cfg_three_pin_i,
    input  wire logic                        cfg_invert_off_i,
    input  wire logic                        status_req_i,
    output logic                             antenna_supply_off_out_o,
    output logic [antsup_pkg::STAT_W-1:0]    hardware_monitor_message_o,
    output logic                             status_valid_o,
    output logic                             three_pin_o
);
    // ------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------
    logic good_s;
    logic present_s;
    logic short_n_s;

    antsup_sync u_sync_good (                      // [R13]
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .async_i (antenna_good_in_i),
        .sync_o  (good_s)
    );

    antsup_sync u_sync_present (                   // [R13]
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .async_i (antenna_present_in_i),
        .sync_o  (present_s)
    );

    antsup_sync u_sync_short (                     // [R13]
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .async_i (antenna_short_low_in_i),
        .sync_o  (short_n_s)
    );

    // ------------------------------------------------------------
    // sticky configuration
    // ------------------------------------------------------------
    // the configuration commands come from same-clock firmware logic;
    // the sticky bits model the one-time-programmable setting, so only a
    // reset of the whole part (fresh programming) can clear them here
    antsup_pkg::antsup_mode_t mode;
    logic                     invert_off;

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            mode <= antsup_pkg::ANTSUP_TWO_PIN;    // [R1]
        end else begin
            case (mode)
                antsup_pkg::ANTSUP_TWO_PIN: begin
                    if (cfg_three_pin_i) begin
                        mode <= antsup_pkg::ANTSUP_THREE_PIN;  // [R5]
                    end
                end
                antsup_pkg::ANTSUP_THREE_PIN: begin
                    mode <= antsup_pkg::ANTSUP_THREE_PIN;      // [R6]
                end
                default: begin
                    mode <= antsup_pkg::ANTSUP_TWO_PIN;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            invert_off <= 1'b0;
        end else if (cfg_invert_off_i) begin
            invert_off <= 1'b1;                    // [R12]
        end
    end

    // ------------------------------------------------------------
    // antenna status decode
    // ------------------------------------------------------------
    logic three;
    logic ant_good;
    logic ant_absent;
    logic ant_short;
    logic next_off;

    assign three = (mode == antsup_pkg::ANTSUP_THREE_PIN);

    always_comb begin
        if (three) begin
            ant_absent = ~present_s;               // [R7]
            ant_short  = ~short_n_s;               // [R8]
            ant_good   = present_s & short_n_s;
        end else begin
            // two-pin cannot tell a short from an open, so a fault is
            // treated as a short to stay on the safe side
            ant_absent = 1'b0;
            ant_short  = ~good_s;                  // [R2]
            ant_good   = good_s;                   // [R2]
        end
        next_off = ant_short | power_save_i;       // [R4]
    end

    // ------------------------------------------------------------
    // supply-off output
    // ------------------------------------------------------------
    logic supply_off;

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            supply_off               <= 1'b0;
            antenna_supply_off_out_o <= 1'b0;
        end else begin
            supply_off               <= next_off;
            // high removes supply in both variants unless inverted
            antenna_supply_off_out_o <= next_off ^ invert_off;  // [R3] [R9] [R12]
        end
    end

    // ------------------------------------------------------------
    // status report
    // ------------------------------------------------------------
    logic [antsup_pkg::STAT_W-1:0] next_stat;

    always_comb begin
        next_stat = antsup_pkg::STAT_RESET;
        next_stat[antsup_pkg::STAT_GOOD_BIT]   = ant_good;
        next_stat[antsup_pkg::STAT_ABSENT_BIT] = ant_absent;
        next_stat[antsup_pkg::STAT_SHORT_BIT]  = ant_short;
        next_stat[antsup_pkg::STAT_OFF_BIT]    = supply_off;
        next_stat[antsup_pkg::STAT_THREE_BIT]  = three;
        next_stat[antsup_pkg::STAT_INV_BIT]    = invert_off;
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            hardware_monitor_message_o <= antsup_pkg::STAT_RESET;
            status_valid_o             <= 1'b0;
        end else begin
            status_valid_o <= status_req_i;
            if (status_req_i) begin
                hardware_monitor_message_o <= next_stat;  // [R10]
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            three_pin_o <= 1'b0;
        end else begin
            three_pin_o <= three;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    property p_reset_two_pin;
        @(posedge clk_i) $rose(rst_n_i) |-> !three_pin_o;
    endproperty
    a_reset_two_pin: assert property (p_reset_two_pin) else $error("not two-pin after reset"); // [R1]

    property p_two_pin_good;
        @(posedge clk_i) disable iff (!rst_n_i)
            (!three && !power_save_i && !invert_off && good_s) |=> !antenna_supply_off_out_o;
    endproperty
    a_two_pin_good: assert property (p_two_pin_good) else $error("supply cut with good antenna"); // [R2]

    property p_two_pin_fault;
        @(posedge clk_i) disable iff (!rst_n_i)
            (!three && !invert_off && !good_s) |=> antenna_supply_off_out_o;
    endproperty
    a_two_pin_fault: assert property (p_two_pin_fault) else $error("supply left on with fault"); // [R3]

    property p_power_save_off;
        @(posedge clk_i) disable iff (!rst_n_i)
            (power_save_i && !invert_off) |=> antenna_supply_off_out_o;
    endproperty
    a_power_save_off: assert property (p_power_save_off) else $error("supply on in power save"); // [R4]

    property p_three_only_cmd;
        @(posedge clk_i) disable iff (!rst_n_i)
            (!three && !cfg_three_pin_i) |=> !three;
    endproperty
    a_three_only_cmd: assert property (p_three_only_cmd) else $error("three-pin without command"); // [R5]

    property p_three_sticky;
        @(posedge clk_i) disable iff (!rst_n_i) three |=> three;
    endproperty
    a_three_sticky: assert property (p_three_sticky) else $error("three-pin selection lost"); // [R6]

    property p_three_short;
        @(posedge clk_i) disable iff (!rst_n_i)
            (three && !invert_off && !short_n_s) |=> antenna_supply_off_out_o;
    endproperty
    a_three_short: assert property (p_three_short) else $error("short did not cut supply"); // [R8]

    property p_three_on;
        @(posedge clk_i) disable iff (!rst_n_i)
            (three && !invert_off && short_n_s && !power_save_i) |=> !antenna_supply_off_out_o;
    endproperty
    a_three_on: assert property (p_three_on) else $error("supply cut without cause"); // [R9]

    property p_absent_report;
        @(posedge clk_i) disable iff (!rst_n_i)
            (status_req_i && three && !present_s) |=>
                (status_valid_o && hardware_monitor_message_o[antsup_pkg::STAT_ABSENT_BIT]);
    endproperty
    a_absent_report: assert property (p_absent_report) else $error("absent antenna not reported"); // [R7] [R10]

    property p_invert;
        @(posedge clk_i) disable iff (!rst_n_i)
            invert_off |=> (antenna_supply_off_out_o == !supply_off);
    endproperty
    a_invert: assert property (p_invert) else $error("inverted polarity wrong"); // [R12]

    property p_sync_delay;
        @(posedge clk_i) disable iff (!rst_n_i)
            $fell(antenna_good_in_i) ##1 !antenna_good_in_i ##1 !antenna_good_in_i |-> !good_s;
    endproperty
    a_sync_delay: assert property (p_sync_delay) else $error("synchroniser latency wrong"); // [R13] [R11]

    property p_reset_outputs;
        @(posedge clk_i)
            !rst_n_i |=> (!antenna_supply_off_out_o && !status_valid_o && !three_pin_o
                && hardware_monitor_message_o == antsup_pkg::STAT_RESET);
    endproperty
    a_reset_outputs: assert property (p_reset_outputs) else $error("outputs not cleared by reset"); // [R1]

    property p_valid_on;
        @(posedge clk_i) disable iff (!rst_n_i)
            status_req_i |=> status_valid_o;
    endproperty
    a_valid_on: assert property (p_valid_on) else $error("status request not answered"); // [R10]

    property p_valid_off;
        @(posedge clk_i) disable iff (!rst_n_i)
            !status_req_i |=> !status_valid_o;
    endproperty
    a_valid_off: assert property (p_valid_off) else $error("status valid without request"); // [R10]

    property p_word_holds;
        @(posedge clk_i) disable iff (!rst_n_i)
            !status_req_i |=> $stable(hardware_monitor_message_o);
    endproperty
    a_word_holds: assert property (p_word_holds) else $error("status word changed without request"); // [R10]

    property p_absent_two_pin;
        @(posedge clk_i) disable iff (!rst_n_i)
            (status_req_i && !three) |=> !hardware_monitor_message_o[antsup_pkg::STAT_ABSENT_BIT];
    endproperty
    a_absent_two_pin: assert property (p_absent_two_pin) else $error("absent reported in two-pin"); // [R2]

    property p_fault_report;
        @(posedge clk_i) disable iff (!rst_n_i)
            (status_req_i && !three && !good_s) |=> (hardware_monitor_message_o[antsup_pkg::STAT_SHORT_BIT]
                && !hardware_monitor_message_o[antsup_pkg::STAT_GOOD_BIT]);
    endproperty
    a_fault_report: assert property (p_fault_report) else $error("two-pin fault not reported"); // [R2] [R10]

    property p_short_report;
        @(posedge clk_i) disable iff (!rst_n_i)
            (status_req_i && three && !short_n_s) |=> hardware_monitor_message_o[antsup_pkg::STAT_SHORT_BIT];
    endproperty
    a_short_report: assert property (p_short_report) else $error("short not reported"); // [R8] [R10]

    property p_good_report;
        @(posedge clk_i) disable iff (!rst_n_i)
            (status_req_i && three && present_s && short_n_s) |=> hardware_monitor_message_o[antsup_pkg::STAT_GOOD_BIT];
    endproperty
    a_good_report: assert property (p_good_report) else $error("good antenna not reported"); // [R7] [R10]

    property p_off_report;
        @(posedge clk_i) disable iff (!rst_n_i)
            (status_req_i && supply_off) |=> hardware_monitor_message_o[antsup_pkg::STAT_OFF_BIT];
    endproperty
    a_off_report: assert property (p_off_report) else $error("supply off not reported"); // [R4] [R10]

    property p_invert_sticky;
        @(posedge clk_i) disable iff (!rst_n_i)
            invert_off |=> invert_off;
    endproperty
    a_invert_sticky: assert property (p_invert_sticky) else $error("polarity inversion lost"); // [R12]

    property p_invert_only_cmd;
        @(posedge clk_i) disable iff (!rst_n_i)
            (!invert_off && !cfg_invert_off_i) |=> !invert_off;
    endproperty
    a_invert_only_cmd: assert property (p_invert_only_cmd) else $error("inversion without command"); // [R12]

    property p_three_pin_flag;
        @(posedge clk_i) disable iff (!rst_n_i)
            three |=> three_pin_o;
    endproperty
    a_three_pin_flag: assert property (p_three_pin_flag) else $error("three-pin flag not shown"); // [R6]

    property p_invert_power_save;
        @(posedge clk_i) disable iff (!rst_n_i)
            (power_save_i && invert_off) |=> !antenna_supply_off_out_o;
    endproperty
    a_invert_power_save: assert property (p_invert_power_save) else $error("inverted cut level wrong"); // [R12]

    property p_sync_rise;
        @(posedge clk_i) disable iff (!rst_n_i)
            $rose(antenna_short_low_in_i) ##1 antenna_short_low_in_i ##1 antenna_short_low_in_i |-> short_n_s;
    endproperty
    a_sync_rise: assert property (p_sync_rise) else $error("short release latency wrong"); // [R13]
endmodule

//--- inc/antsup_pkg.sv
package antsup_pkg;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned SYNC_STAGES   = 2;

    // ------------------------------------------------------------
    // status word layout
    // ------------------------------------------------------------
    localparam int unsigned STAT_W          = 6;
    localparam int unsigned STAT_GOOD_BIT   = 0;
    localparam int unsigned STAT_ABSENT_BIT = 1;
    localparam int unsigned STAT_SHORT_BIT  = 2;
    localparam int unsigned STAT_OFF_BIT    = 3;
    localparam int unsigned STAT_THREE_BIT  = 4;
    localparam int unsigned STAT_INV_BIT    = 5;
    localparam logic [5:0]  STAT_RESET      = 6'h00;

    // ------------------------------------------------------------
    // mode encoding
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ANTSUP_TWO_PIN   = 2'h1,
        ANTSUP_THREE_PIN = 2'h2
    } antsup_mode_t;
endpackage

//--- tb/antsup_ant_model.sv
`timescale 1ns/1ps
// --------------------------------------------------------
// antenna supply switch and current sense, behavioural
// --------------------------------------------------------
module antsup_ant_model (
    input  wire logic short_i,
    input  wire logic absent_i,
    output logic      good_o,
    output logic      present_o,
    output logic      short_low_o
);
    // sense buffers are open drain into pulled-up pins, so a quiet line reads high
    assign good_o      = ~short_i;
    assign present_o   = ~absent_i;
    assign short_low_o = ~short_i;
endmodule

//--- tb/tb_antsup_top.sv
`timescale 1ns/1ps
module tb_antsup_top;
    logic                          clk;
    logic                          rst_n;
    logic                          ps;
    logic                          cfg3;
    logic                          cfginv;
    logic                          req;
    logic                          shrt;
    logic                          absent;
    logic                          good;
    logic                          present;
    logic                          short_low;
    logic                          off;
    logic                          valid;
    logic                          three;
    logic [antsup_pkg::STAT_W-1:0] stat;
    int                            n_fail = 0;
    int                            n_compared = 0;
    int                            cycles = 0;

    antsup_ant_model u_antsup_ant_model (.short_i(shrt), .absent_i(absent), .good_o(good),
        .present_o(present), .short_low_o(short_low));
    antsup_top u_antsup_top (.clk_i(clk), .rst_n_i(rst_n), .antenna_good_in_i(good),
        .antenna_present_in_i(present), .antenna_short_low_in_i(short_low), .power_save_i(ps),
        .cfg_three_pin_i(cfg3), .cfg_invert_off_i(cfginv), .status_req_i(req),
        .antenna_supply_off_out_o(off), .hardware_monitor_message_o(stat),
        .status_valid_o(valid), .three_pin_o(three));

    // --------------------------------------------------------
    // clock, watchdog and helpers
    // --------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // whole run needs about fifty cycles, so this only trips on a hang
    always @(posedge clk) begin
        cycles++;
        if (cycles == 2000) begin
            n_fail++;
            tally_and_finish();
        end
    end

    task automatic tally_and_finish();
        if (n_fail == 0 && n_compared > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic step(input int n);
        repeat (n) @(negedge clk);
    endtask

    task automatic status(input logic [7:0] exp);
        req = 1'b1;
        step(1);
        req = 1'b0;
        check("valid", {7'h00, valid}, 8'h01);
        check("status", {2'h0, stat}, exp);
        step(1);
        check("valid", {7'h00, valid}, 8'h00);
    endtask

    // --------------------------------------------------------
    // scenarios
    // --------------------------------------------------------
    task automatic t_reset();
        step(6);
        check("off", {7'h00, off}, 8'h00);
        check("stat", {2'h0, stat}, 8'h00);
        rst_n = 1'b1;
        step(3);
        check("three", {7'h00, three}, 8'h00);
        check("off", {7'h00, off}, 8'h00);
        status(8'h01);
    endtask

    task automatic t_two_pin();
        shrt = 1'b1;
        step(2);
        check("off", {7'h00, off}, 8'h00);
        step(1);
        check("off", {7'h00, off}, 8'h01);
        status(8'h0c);
        shrt = 1'b0;
        absent = 1'b1;
        step(4);
        check("off", {7'h00, off}, 8'h00);
        status(8'h01);
        absent = 1'b0;
    endtask

    task automatic t_power_save();
        ps = 1'b1;
        step(1);
        check("off", {7'h00, off}, 8'h01);
        status(8'h09);
        ps = 1'b0;
        step(1);
        check("off", {7'h00, off}, 8'h00);
    endtask

    task automatic t_three_pin();
        cfg3 = 1'b1;
        step(1);
        cfg3 = 1'b0;
        step(1);
        check("three", {7'h00, three}, 8'h01);
        absent = 1'b1;
        step(4);
        check("three", {7'h00, three}, 8'h01);
        check("off", {7'h00, off}, 8'h00);
        status(8'h12);
        absent = 1'b0;
        shrt = 1'b1;
        step(2);
        check("off", {7'h00, off}, 8'h00);
        step(1);
        check("off", {7'h00, off}, 8'h01);
        status(8'h1c);
        shrt = 1'b0;
        step(3);
        check("off", {7'h00, off}, 8'h00);
        status(8'h11);
    endtask

    task automatic t_invert();
        cfginv = 1'b1;
        step(1);
        cfginv = 1'b0;
        step(1);
        check("off", {7'h00, off}, 8'h01);
        ps = 1'b1;
        step(1);
        check("off", {7'h00, off}, 8'h00);
        ps = 1'b0;
        step(1);
        status(8'h31);
    endtask

    initial begin
        rst_n = 1'b0;
        ps = 1'b0;
        cfg3 = 1'b0;
        cfginv = 1'b0;
        req = 1'b0;
        shrt = 1'b0;
        absent = 1'b0;
        t_reset();
        t_two_pin();
        t_power_save();
        t_three_pin();
        t_invert();
        tally_and_finish();
    end
endmodule
